// >>> orbt_bus_partner.sv
`timescale 1ns/1ns
// Other logic on both buses; it lets go of a port the device drives
module orbt_bus_partner
  import orbt_pkg::*;
(
  input  wire logic [ORBT_WIDTH-1:0] a_value,
  input  wire logic [ORBT_WIDTH-1:0] b_value,
  input  wire logic [ORBT_WIDTH-1:0] a_dev,
  input  wire logic [ORBT_WIDTH-1:0] b_dev,
  input  wire logic                  a_oe_n,
  input  wire logic                  b_oe_n,
  output logic      [ORBT_WIDTH-1:0] a_pin,
  output logic      [ORBT_WIDTH-1:0] b_pin
);
  // Pin level from whichever party drives
  assign a_pin = (a_oe_n == ORBT_PIN_DRIVE) ? a_dev : a_value;
  assign b_pin = (b_oe_n == ORBT_PIN_DRIVE) ? b_dev : b_value;
endmodule

// >>> orbt_fifo.sv
`timescale 1ns/1ns
module orbt_fifo
  import orbt_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = ORBT_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];   // Word storage
  logic [AW-1:0]    wr_ptr_reg;        // Write pointer
  logic [AW-1:0]    rd_ptr_reg;        // Read pointer
  logic [AW:0]      count_reg;         // Fill level
  logic             push;
  logic             pop;

  // Pointer advance with wrap
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Honest full and empty
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  chk_fifo_no_over : assert property (@(posedge clk) disable iff (sys_rst)
    count_reg <= (AW+1)'(DEPTH)) else $error("fifo level above depth");
endmodule

// >>> orbt_pkg.sv
package orbt_pkg;
  // Data width of each port
  localparam int ORBT_WIDTH = 8;
  // FIFO depth in the capture path
  localparam int ORBT_DEPTH = 4;
  // Output enable levels (active low)
  localparam logic ORBT_OE_ON  = 1'b0;
  // Direction codes
  localparam logic ORBT_DIR_TO_A = 1'b0;
  localparam logic ORBT_DIR_TO_B = 1'b1;
  // Source select codes
  localparam logic ORBT_SEL_LIVE   = 1'b0;
  localparam logic ORBT_SEL_STORED = 1'b1;
  // Pin output enable: low while driving
  localparam logic ORBT_PIN_DRIVE = 1'b0;
  localparam logic ORBT_PIN_FLOAT = 1'b1;

  // Drive mode of the transceiver
  typedef enum logic [1:0] {
    ORBT_MODE_ISOLATE = 2'b00,
    ORBT_MODE_DRIVE_A = 2'b01,
    ORBT_MODE_DRIVE_B = 2'b10
  } orbt_mode_t;

  // Output control inputs grouped
  typedef struct packed {
    logic out_enable_n;
    logic direction;
    logic a_output_source_select;
    logic b_output_source_select;
  } orbt_ctrl_t;

  // One captured word with its source
  typedef struct packed {
    logic                  from_b;
    logic [ORBT_WIDTH-1:0] data;
  } orbt_word_t;
endpackage

// >>> orbt_transceiver.sv
`timescale 1ns/1ns
module orbt_transceiver
  import orbt_pkg::*;
#(
  parameter int WIDTH = ORBT_WIDTH,
  parameter int DEPTH = ORBT_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             a_to_b_capture_clock,
  input  wire logic             b_to_a_capture_clock,
  input  wire orbt_ctrl_t       ctrl,
  input  wire logic [WIDTH-1:0] a_port_data_in,
  output logic      [WIDTH-1:0] a_port_data_out,
  output logic                  a_port_data_oe_n,
  input  wire logic [WIDTH-1:0] b_port_data_in,
  output logic      [WIDTH-1:0] b_port_data_out,
  output logic                  b_port_data_oe_n,
  output logic      [WIDTH-1:0] a_to_b_stored,
  output logic      [WIDTH-1:0] b_to_a_stored,
  output logic                  capture_valid,
  input  wire logic             capture_ready,
  output logic      [WIDTH:0]   capture_word,
  output logic                  capture_overflow
);
  logic [WIDTH-1:0] ab_store_reg;      // A-to-B storage
  logic [WIDTH-1:0] ba_store_reg;      // B-to-A storage
  logic             ab_clk_dly_reg;    // Previous A capture clock level
  logic             ba_clk_dly_reg;    // Previous B capture clock level
  logic             ab_rise;           // A capture rising edge
  logic             ba_rise;           // B capture rising edge
  logic             ab_pend_reg;       // A word awaiting FIFO entry
  logic             ba_pend_reg;       // B word awaiting FIFO entry
  logic             ovf_reg;           // Sticky lost-capture flag
  logic             fifo_in_valid;
  logic             fifo_in_ready;
  logic [WIDTH:0]   fifo_in_data;
  orbt_mode_t       mode;              // Current drive mode

  // Rising edge of a sampled level
  function automatic logic rise(input logic now, input logic was);
    return now && !was;
  endfunction

  assign ab_rise = rise(a_to_b_capture_clock, ab_clk_dly_reg);
  assign ba_rise = rise(b_to_a_capture_clock, ba_clk_dly_reg);

  // Edge detect history for capture clocks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ab_clk_dly_reg <= 1'b1;
      ba_clk_dly_reg <= 1'b1;
    end else begin
      ab_clk_dly_reg <= a_to_b_capture_clock;
      ba_clk_dly_reg <= b_to_a_capture_clock;
    end
  end

  // A-to-B storage, no reset, not gated by controls
  always_ff @(posedge clk) begin
    if (ab_rise) begin
      ab_store_reg <= a_port_data_in;
    end
  end

  // B-to-A storage, no reset, not gated by controls
  always_ff @(posedge clk) begin
    if (ba_rise) begin
      ba_store_reg <= b_port_data_in;
    end
  end

  assign a_to_b_stored = ab_store_reg;
  assign b_to_a_stored = ba_store_reg;

  // Drive mode from enable and direction only
  always_comb begin
    if (ctrl.out_enable_n != ORBT_OE_ON) begin
      mode = ORBT_MODE_ISOLATE;
    end else if (ctrl.direction == ORBT_DIR_TO_A) begin
      mode = ORBT_MODE_DRIVE_A;
    end else begin
      mode = ORBT_MODE_DRIVE_B;
    end
  end

  // Port enables, at most one driven
  always_comb begin
    a_port_data_oe_n = ORBT_PIN_FLOAT;
    b_port_data_oe_n = ORBT_PIN_FLOAT;
    case (mode)
      ORBT_MODE_DRIVE_A: a_port_data_oe_n = ORBT_PIN_DRIVE;
      ORBT_MODE_DRIVE_B: b_port_data_oe_n = ORBT_PIN_DRIVE;
      default: ;
    endcase
  end

  // A port data source
  always_comb begin
    if (ctrl.a_output_source_select == ORBT_SEL_STORED) begin
      a_port_data_out = ba_store_reg;
    end else begin
      a_port_data_out = b_port_data_in;
    end
  end

  // B port data source
  always_comb begin
    if (ctrl.b_output_source_select == ORBT_SEL_STORED) begin
      b_port_data_out = ab_store_reg;
    end else begin
      b_port_data_out = a_port_data_in;
    end
  end

  // Captured words queue for a reader; A before B on a shared edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ab_pend_reg <= 1'b0;
      ba_pend_reg <= 1'b0;
    end else begin
      if (ab_rise) begin
        ab_pend_reg <= 1'b1;
      end else if (fifo_in_valid && fifo_in_ready && ab_pend_reg) begin
        ab_pend_reg <= 1'b0;
      end
      if (ba_rise) begin
        ba_pend_reg <= 1'b1;
      end else if (fifo_in_valid && fifo_in_ready && !ab_pend_reg) begin
        ba_pend_reg <= 1'b0;
      end
    end
  end

  // Lost capture: new edge while previous word still pending
  // A word that enters the FIFO on that same edge is not lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_reg <= 1'b0;
    end else if ((ab_rise && ab_pend_reg && !fifo_in_ready)
                 || (ba_rise && ba_pend_reg && !(fifo_in_ready && !ab_pend_reg))) begin
      ovf_reg <= 1'b1;
    end
  end

  assign capture_overflow = ovf_reg;
  assign fifo_in_valid    = ab_pend_reg || ba_pend_reg;
  assign fifo_in_data     = ab_pend_reg ? {1'b0, ab_store_reg} : {1'b1, ba_store_reg};

  // Capture FIFO
  orbt_fifo #(
    .WIDTH (WIDTH + 1),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (capture_valid),
    .out_ready (capture_ready),
    .out_data  (capture_word)
  );

  // Checks
  chk_one_port_driven : assert property (@(posedge clk) disable iff (sys_rst)
    !(a_port_data_oe_n == ORBT_PIN_DRIVE && b_port_data_oe_n == ORBT_PIN_DRIVE))
    else $error("both ports driven");

  chk_isolate_no_drive : assert property (@(posedge clk) disable iff (sys_rst)
    ctrl.out_enable_n |-> (a_port_data_oe_n && b_port_data_oe_n))
    else $error("drive while isolated");

  chk_ab_capture : assert property (@(posedge clk) disable iff (sys_rst)
    ab_rise |=> ab_store_reg == $past(a_port_data_in))
    else $error("A capture missed");

  chk_ba_capture : assert property (@(posedge clk) disable iff (sys_rst)
    ba_rise |=> ba_store_reg == $past(b_port_data_in))
    else $error("B capture missed");

  // Case equality: storage is unloaded after power-up and must still hold
  chk_hold_static : assert property (@(posedge clk) disable iff (sys_rst)
    (!ab_rise && !ba_rise)
    |=> (ab_store_reg === $past(ab_store_reg)) && (ba_store_reg === $past(ba_store_reg)))
    else $error("storage changed without edge");

  // Capture edge, then word waiting for the FIFO
  sequence s_ab_edge;
    ab_rise;
  endsequence

  sequence s_ab_waiting;
    ab_pend_reg;
  endsequence

  chk_ab_queued : assert property (@(posedge clk) disable iff (sys_rst)
    s_ab_edge |=> s_ab_waiting)
    else $error("A capture not queued");

  chk_a_live_path : assert property (@(posedge clk) disable iff (sys_rst)
    (!ctrl.out_enable_n && !ctrl.direction && !ctrl.a_output_source_select)
    |-> (!a_port_data_oe_n && a_port_data_out == b_port_data_in))
    else $error("A live path wrong");

  chk_a_stored_path : assert property (@(posedge clk) disable iff (sys_rst)
    (!ctrl.out_enable_n && !ctrl.direction && ctrl.a_output_source_select)
    |-> (!a_port_data_oe_n && a_port_data_out == ba_store_reg))
    else $error("A stored path wrong");

  chk_b_live_path : assert property (@(posedge clk) disable iff (sys_rst)
    (!ctrl.out_enable_n && ctrl.direction && !ctrl.b_output_source_select)
    |-> (!b_port_data_oe_n && b_port_data_out == a_port_data_in))
    else $error("B live path wrong");

  chk_b_stored_path : assert property (@(posedge clk) disable iff (sys_rst)
    (!ctrl.out_enable_n && ctrl.direction && ctrl.b_output_source_select)
    |-> (!b_port_data_oe_n && b_port_data_out == ab_store_reg))
    else $error("B stored path wrong");

  chk_both_isolated : assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl.out_enable_n && ab_rise && ba_rise)
    |=> (ab_store_reg == $past(a_port_data_in) && ba_store_reg == $past(b_port_data_in)))
    else $error("isolated dual capture failed");
endmodule

// >>> tb.sv
`timescale 1ns/1ns
module tb
  import orbt_pkg::*;
;
  logic             clk, sys_rst, ab_clk, ba_clk, ready;
  orbt_ctrl_t       ctrl;
  logic [7:0]       pa, pb, a_pin, b_pin, a_out, b_out, ab_st, ba_st;
  logic             a_oe_n, b_oe_n, cap_valid, cap_ovf;
  logic [8:0]       cap_word;
  logic [31:0]      seed;
  logic [7:0]       ref_ab, ref_ba;  // Model storage
  logic [8:0]       exp_q[$];        // Model capture order
  int               n_mismatch, total_checks, i;

  orbt_transceiver u_orbt_transceiver (.clk(clk), .sys_rst(sys_rst),
    .a_to_b_capture_clock(ab_clk), .b_to_a_capture_clock(ba_clk), .ctrl(ctrl),
    .a_port_data_in(a_pin), .a_port_data_out(a_out), .a_port_data_oe_n(a_oe_n),
    .b_port_data_in(b_pin), .b_port_data_out(b_out), .b_port_data_oe_n(b_oe_n),
    .a_to_b_stored(ab_st), .b_to_a_stored(ba_st), .capture_valid(cap_valid),
    .capture_ready(ready), .capture_word(cap_word), .capture_overflow(cap_ovf));
  orbt_bus_partner u_orbt_bus_partner (.a_value(pa), .b_value(pb), .a_dev(a_out),
    .b_dev(b_out), .a_oe_n(a_oe_n), .b_oe_n(b_oe_n), .a_pin(a_pin), .b_pin(b_pin));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Compare data and words
  task automatic check_val(input string what, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare single flags
  task automatic check_flag(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Verdict and stop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One control setting with optional capture edges
  task automatic step(input logic [3:0] c, input logic [1:0] sel);
    logic       drv_a, drv_b;
    logic [7:0] pin_a, pin_b;
    @(negedge clk);
    ctrl = c;
    pa = 8'(rnd());
    pb = 8'(rnd());
    ab_clk = sel[0];
    ba_clk = sel[1];
    drv_a = (ctrl.out_enable_n == ORBT_OE_ON) && (ctrl.direction == ORBT_DIR_TO_A);
    drv_b = (ctrl.out_enable_n == ORBT_OE_ON) && (ctrl.direction == ORBT_DIR_TO_B);
    pin_a = drv_a ? (ctrl.a_output_source_select ? ref_ba : pb) : pa;
    pin_b = drv_b ? (ctrl.b_output_source_select ? ref_ab : pa) : pb;
    // A word queued before B on simultaneous edges
    if (sel[0]) begin
      ref_ab = pin_a;
      exp_q.push_back({1'b0, pin_a});
    end
    if (sel[1]) begin
      ref_ba = pin_b;
      exp_q.push_back({1'b1, pin_b});
    end
    @(negedge clk);
    ab_clk = 1'b0;
    ba_clk = 1'b0;
    @(negedge clk);
    check_val("a_to_b_stored", {1'b0, ref_ab}, {1'b0, ab_st});
    check_val("b_to_a_stored", {1'b0, ref_ba}, {1'b0, ba_st});
    check_flag("a_port_data_oe_n", !drv_a, a_oe_n);
    check_flag("b_port_data_oe_n", !drv_b, b_oe_n);
    if (drv_a) begin
      check_val("a_port_data_out", {1'b0, ctrl.a_output_source_select ? ref_ba : pb},
                {1'b0, a_out});
    end
    if (drv_b) begin
      check_val("b_port_data_out", {1'b0, ctrl.b_output_source_select ? ref_ab : pa},
                {1'b0, b_out});
    end
  endtask

  // Drained words against the model
  always @(posedge clk) begin
    if (cap_valid === 1'b1 && ready === 1'b1) begin
      if (exp_q.size() > 0) begin
        check_val("capture_word", exp_q.pop_front(), cap_word);
      end else begin
        n_mismatch++;
        $display("wrong value capture_word expected none seen %h", cap_word);
      end
    end
  end

  // Main sequence
  initial begin
    seed = 32'h46cf;
    sys_rst = 1'b1;
    ab_clk = 1'b0;
    ba_clk = 1'b0;
    ready = 1'b1;
    ctrl = 4'h8;
    pa = 8'h00;
    pb = 8'h00;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    step(4'h8, 2'b11);
    // Every control code, random edges
    for (i = 0; i < 64; i++) begin
      step(i[3:0], 2'(rnd()));
    end
    // Fill the FIFO while the reader stalls
    repeat (2) @(negedge clk);
    ready = 1'b0;
    for (i = 0; i < 6; i++) begin
      step(4'h8, 2'b01);
      if (i == 4) begin
        check_flag("capture_overflow", 1'b0, cap_ovf);
      end
    end
    check_flag("capture_overflow", 1'b1, cap_ovf);
    check_flag("capture_valid", 1'b1, cap_valid);
    // Fifth word was overwritten; the sixth still waits to enter
    exp_q.delete(exp_q.size() - 2);
    @(negedge clk);
    ready = 1'b1;
    // Drain until empty
    for (i = 0; i < 40 && cap_valid !== 1'b0; i++) begin
      @(negedge clk);
    end
    if (cap_valid !== 1'b0 || exp_q.size() != 0) begin
      n_mismatch++;
      $display("wrong value drain expected empty seen busy");
      end_of_test();
    end
    // Reset keeps storage
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check_val("a_to_b_stored", {1'b0, ref_ab}, {1'b0, ab_st});
    check_flag("capture_overflow", 1'b0, cap_ovf);
    for (i = 0; i < 16; i++) begin
      step(4'(rnd()), 2'(rnd()));
    end
    repeat (8) @(negedge clk);
    check_val("pending words", 9'h000, 9'(exp_q.size()));
    end_of_test();
  end
endmodule
